//--- rtl/cfp_pkg.sv
// Shared constants and types for the cell fault protection timer logic
package cfp_pkg;

  // ****************************************************************
  // Clock and tick rates
  // ****************************************************************
  localparam int CLK_PERIOD_PS = 5000;
  localparam int US_PS = 1000000;
  localparam int US_PER_MS = 1000;
  // Cycles per microsecond tick, derived from the clock period
  localparam int US_DIV_CYC = US_PS / CLK_PERIOD_PS;
  localparam int DIV_W = 16;
  localparam int CNT_W = 13;
  typedef logic [CNT_W-1:0] cfp_cnt_t;
  typedef logic [DIV_W-1:0] cfp_div_t;

  // ****************************************************************
  // Fault detection delays (ms, short circuit in us)
  // ****************************************************************
  // Overcharge options 0.25 s, 1 s, 1.25 s and 4.5 s held in ms
  localparam cfp_cnt_t OVP_DLY_MS [4] = '{13'h0FA, 13'h3E8, 13'h4E2, 13'h1194};
  localparam cfp_cnt_t UVP_DLY_MS [4] = '{13'h014, 13'h060, 13'h07D, 13'h090};
  localparam cfp_cnt_t OCD_DLY_MS [4] = '{13'h008, 13'h010, 13'h014, 13'h030};
  localparam cfp_cnt_t OCC_DLY_MS [4] = '{13'h004, 13'h006, 13'h008, 13'h010};
  localparam cfp_cnt_t SCC_DLY_US = 13'h0FA;
  localparam cfp_cnt_t REC_MS_DEF = 13'h008;

  // ****************************************************************
  // Threshold ranges in mV and their highest legal codes
  // ****************************************************************
  localparam int OVP_MIN_MV = 3850;
  localparam int OVP_MAX_MV = 4600;
  localparam int UVP_MIN_MV = 2000;
  localparam int UVP_MAX_MV = 2800;
  localparam int VT_STEP_MV = 50;
  localparam int OCD_MIN_MV = 90;
  localparam int OCD_MAX_MV = 200;
  localparam int OCC_MIN_MV = 45;
  localparam int OCC_MAX_MV = 155;
  localparam int OC_STEP_MV = 5;
  localparam int SCC_MIN_MV = 300;
  localparam int SCC_MAX_MV = 600;
  localparam int SCC_STEP_MV = 100;
  localparam logic [3:0] OVP_CODE_MAX = 4'((OVP_MAX_MV - OVP_MIN_MV) / VT_STEP_MV);
  localparam logic [4:0] UVP_CODE_MAX = 5'((UVP_MAX_MV - UVP_MIN_MV) / VT_STEP_MV);
  localparam logic [4:0] OCD_CODE_MAX = 5'((OCD_MAX_MV - OCD_MIN_MV) / OC_STEP_MV);
  localparam logic [4:0] OCC_CODE_MAX = 5'((OCC_MAX_MV - OCC_MIN_MV) / OC_STEP_MV);
  localparam logic [1:0] SCC_CODE_MAX = 2'((SCC_MAX_MV - SCC_MIN_MV) / SCC_STEP_MV);

  // ****************************************************************
  // Fault indices and register map
  // ****************************************************************
  localparam int NUM_FAULTS = 5;
  localparam int FI_OVP = 0;
  localparam int FI_UVP = 1;
  localparam int FI_OCD = 2;
  localparam int FI_SCC = 3;
  localparam int FI_OCC = 4;
  localparam int ADDR_W = 4;
  localparam logic [3:0] REG_DLY_ADDR = 4'h0;
  localparam logic [3:0] REG_THR_ADDR = 4'h4;
  localparam logic [3:0] REG_STAT_ADDR = 4'h8;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [1:0] {
    SEL_DLY = 2'b00,
    SEL_THR = 2'b01,
    SEL_STAT = 2'b10,
    SEL_NONE = 2'b11
  } cfp_sel_e;

  // Synchronised comparator results from the analog front end
  typedef struct packed {
    logic occ_release;
    logic occ_below;
    logic scc_above;
    logic ocd_above;
    logic diff_gt_1v;
    logic uvp_above_hys;
    logic uvp_below;
    logic ovp_below_hys;
    logic ovp_above;
  } cfp_cmp_s;

  // Threshold codes, ovp in the low bits of the register
  typedef struct packed {
    logic [1:0] short_circuit_fault;
    logic [4:0] occ;
    logic [4:0] discharge_overcurrent_fault;
    logic [4:0] overdischarge_fault;
    logic [3:0] overcharge_fault;
  } cfp_thr_s;

  // Delay option selects, ovp in the low bits of the register
  typedef struct packed {
    logic [1:0] occ;
    logic [1:0] discharge_overcurrent_fault;
    logic [1:0] overdischarge_fault;
    logic [1:0] overcharge_fault;
  } cfp_dly_s;

  typedef struct packed {
    logic [8:0] sync1;
    logic [8:0] sync2;
    cfp_div_t us_cnt;
    cfp_div_t ms_cnt;
    logic us_tick;
    logic ms_tick;
    logic [NUM_FAULTS-1:0] fault;
    logic [NUM_FAULTS-1:0][CNT_W-1:0] det;
    logic [NUM_FAULTS-1:0][CNT_W-1:0] rec;
    logic chg_gate;
    logic dsg_gate;
    cfp_dly_s dly;
    cfp_thr_s thr;
    logic aw_got;
    logic w_got;
    logic [ADDR_W-1:0] waddr;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
  } cfp_state_s;

  // Gates on and no fault after reset
  localparam cfp_state_s STATE_RST = '{chg_gate: 1'b1, dsg_gate: 1'b1, default: '0};

endpackage

//--- rtl/cfp_top.sv
// Fault timers, gate drive control and AXI4-Lite registers of a cell protector
//
// Our own choices: the address map and the AXI4-Lite interface to the registers.
`timescale 1ns/1ps

module cfp_top #(
  parameter cfp_pkg::cfp_div_t US_DIV = cfp_pkg::cfp_div_t'(cfp_pkg::US_DIV_CYC),
  parameter cfp_pkg::cfp_div_t MS_DIV = cfp_pkg::cfp_div_t'(cfp_pkg::US_PER_MS),
  parameter cfp_pkg::cfp_cnt_t REC_MS = cfp_pkg::REC_MS_DEF
) (
  // Clock and reset
  input wire logic REF_CLK_I,
  input wire logic RST_I,
  // Analog comparator results, asynchronous
  input wire cfp_pkg::cfp_cmp_s COMPARATOR_I,
  // Gate drives and threshold codes to the analog side
  output logic CHARGE_GATE_DRIVE_O,
  output logic DISCHARGE_GATE_DRIVE_O,
  output cfp_pkg::cfp_thr_s THRESH_SEL_O,
  // AXI4-Lite write address and data
  input wire logic [cfp_pkg::ADDR_W-1:0] AWADDR_I,
  input wire logic AWVALID_I,
  output logic AWREADY_O,
  input wire logic [31:0] WDATA_I,
  input wire logic [3:0] WSTRB_I,
  input wire logic WVALID_I,
  output logic WREADY_O,
  // AXI4-Lite write response
  output logic [1:0] BRESP_O,
  output logic BVALID_O,
  input wire logic BREADY_I,
  // AXI4-Lite read
  input wire logic [cfp_pkg::ADDR_W-1:0] ARADDR_I,
  input wire logic ARVALID_I,
  output logic ARREADY_O,
  output logic [31:0] RDATA_O,
  output logic [1:0] RRESP_O,
  output logic RVALID_O,
  input wire logic RREADY_I
);

  // ****************************************************************
  // Helper functions
  // ****************************************************************

  // Address decode, shared by the write and the read path
  function automatic cfp_pkg::cfp_sel_e reg_sel(input logic [cfp_pkg::ADDR_W-1:0] addr);
    case (addr)
      cfp_pkg::REG_DLY_ADDR: reg_sel = cfp_pkg::SEL_DLY;
      cfp_pkg::REG_THR_ADDR: reg_sel = cfp_pkg::SEL_THR;
      cfp_pkg::REG_STAT_ADDR: reg_sel = cfp_pkg::SEL_STAT;
      default: reg_sel = cfp_pkg::SEL_NONE;
    endcase
  endfunction

  // Byte lane merge under the write strobes
  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] wd,
                                        input logic [3:0] strb);
    merge = old;
    for (int b = 0; b < 4; b++) begin
      if (strb[b]) begin
        merge[b*8 +: 8] = wd[b*8 +: 8];
      end
    end
  endfunction

  // Out-of-range codes are pinned to the top of each range
  function automatic cfp_pkg::cfp_thr_s clamp(input cfp_pkg::cfp_thr_s t);
    clamp = t;
    if (t.overcharge_fault > cfp_pkg::OVP_CODE_MAX) begin
      clamp.overcharge_fault = cfp_pkg::OVP_CODE_MAX;
    end
    if (t.overdischarge_fault > cfp_pkg::UVP_CODE_MAX) begin
      clamp.overdischarge_fault = cfp_pkg::UVP_CODE_MAX;
    end
    if (t.discharge_overcurrent_fault > cfp_pkg::OCD_CODE_MAX) begin
      clamp.discharge_overcurrent_fault = cfp_pkg::OCD_CODE_MAX;
    end
    if (t.occ > cfp_pkg::OCC_CODE_MAX) begin
      clamp.occ = cfp_pkg::OCC_CODE_MAX;
    end
  endfunction

  // ****************************************************************
  // State and decoded conditions
  // ****************************************************************
  cfp_pkg::cfp_state_s s;
  cfp_pkg::cfp_state_s n;
  cfp_pkg::cfp_cmp_s cmp;
  logic [cfp_pkg::NUM_FAULTS-1:0] cond;
  logic [cfp_pkg::NUM_FAULTS-1:0] rel;
  logic [cfp_pkg::NUM_FAULTS-1:0] tick;
  cfp_pkg::cfp_cnt_t lim [cfp_pkg::NUM_FAULTS];
  logic aw_rdy;
  logic w_rdy;
  logic ar_rdy;

  // Only the second synchroniser stage is ever looked at
  assign cmp = cfp_pkg::cfp_cmp_s'(s.sync2);

  // Fault detect conditions
  assign cond[cfp_pkg::FI_OVP] = cmp.ovp_above;
  assign cond[cfp_pkg::FI_UVP] = cmp.uvp_below;
  assign cond[cfp_pkg::FI_OCD] = cmp.ocd_above;
  assign cond[cfp_pkg::FI_SCC] = cmp.scc_above;
  assign cond[cfp_pkg::FI_OCC] = cmp.occ_below;

  // Release conditions; a loaded pack may also leave overcharge once below threshold
  assign rel[cfp_pkg::FI_OVP] = (cmp.ovp_below_hys & ~cmp.occ_below) | (cmp.ocd_above & ~cmp.ovp_above);
  assign rel[cfp_pkg::FI_UVP] = cmp.uvp_above_hys & cmp.diff_gt_1v;
  assign rel[cfp_pkg::FI_OCD] = cmp.diff_gt_1v;
  assign rel[cfp_pkg::FI_SCC] = cmp.diff_gt_1v;
  assign rel[cfp_pkg::FI_OCC] = cmp.occ_release;

  // Short circuit runs on the microsecond tick, all others on milliseconds
  assign tick[cfp_pkg::FI_OVP] = s.ms_tick;
  assign tick[cfp_pkg::FI_UVP] = s.ms_tick;
  assign tick[cfp_pkg::FI_OCD] = s.ms_tick;
  assign tick[cfp_pkg::FI_SCC] = s.us_tick;
  assign tick[cfp_pkg::FI_OCC] = s.ms_tick;

  // Delay limits from the selected options, fixed for short circuit
  assign lim[cfp_pkg::FI_OVP] = cfp_pkg::OVP_DLY_MS[s.dly.overcharge_fault];
  assign lim[cfp_pkg::FI_UVP] = cfp_pkg::UVP_DLY_MS[s.dly.overdischarge_fault];
  assign lim[cfp_pkg::FI_OCD] = cfp_pkg::OCD_DLY_MS[s.dly.discharge_overcurrent_fault];
  assign lim[cfp_pkg::FI_OCC] = cfp_pkg::OCC_DLY_MS[s.dly.occ];
  assign lim[cfp_pkg::FI_SCC] = cfp_pkg::SCC_DLY_US;

  // Ready while no response is pending, so one transfer of each kind at a time
  assign aw_rdy = ~s.aw_got & ~s.bvalid;
  assign w_rdy = ~s.w_got & ~s.bvalid;
  assign ar_rdy = ~s.rvalid;

  // ****************************************************************
  // Next state
  // ****************************************************************
  always_comb begin
    cfp_pkg::cfp_sel_e wsel;
    cfp_pkg::cfp_sel_e rsel;
    wsel = reg_sel(s.waddr);
    rsel = reg_sel(ARADDR_I);
    n = s;
    // Two-stage synchroniser for the comparators
    n.sync1 = COMPARATOR_I;
    n.sync2 = s.sync1;
    // Tick dividers: one-cycle enables, microseconds then milliseconds
    n.us_tick = 1'b0;
    n.ms_tick = 1'b0;
    if (s.us_cnt == US_DIV - cfp_pkg::cfp_div_t'(1)) begin
      n.us_cnt = '0;
      n.us_tick = 1'b1;
      if (s.ms_cnt == MS_DIV - cfp_pkg::cfp_div_t'(1)) begin
        n.ms_cnt = '0;
        n.ms_tick = 1'b1;
      end else begin
        n.ms_cnt = s.ms_cnt + cfp_pkg::cfp_div_t'(1);
      end
    end else begin
      n.us_cnt = s.us_cnt + cfp_pkg::cfp_div_t'(1);
    end
    // Detection and recovery timers per fault
    for (int i = 0; i < cfp_pkg::NUM_FAULTS; i++) begin
      if (!s.fault[i]) begin
        n.rec[i] = '0;
        if (!cond[i]) begin
          n.det[i] = '0;
        end else if (tick[i]) begin
          if (s.det[i] + cfp_pkg::cfp_cnt_t'(1) >= lim[i]) begin
            n.fault[i] = 1'b1;
            n.det[i] = '0;
          end else begin
            n.det[i] = s.det[i] + cfp_pkg::cfp_cnt_t'(1);
          end
        end
      end else begin
        n.det[i] = '0;
        // A recurrence or lost release condition restarts recovery
        if (cond[i] || !rel[i]) begin
          n.rec[i] = '0;
        end else if (s.ms_tick) begin
          if (s.rec[i] + cfp_pkg::cfp_cnt_t'(1) >= REC_MS) begin
            n.fault[i] = 1'b0;
            n.rec[i] = '0;
          end else begin
            n.rec[i] = s.rec[i] + cfp_pkg::cfp_cnt_t'(1);
          end
        end
      end
    end
    // Gate drives: high turns the FET on
    n.chg_gate = ~(n.fault[cfp_pkg::FI_OVP] | n.fault[cfp_pkg::FI_OCC]);
    n.dsg_gate = ~(n.fault[cfp_pkg::FI_UVP] | n.fault[cfp_pkg::FI_OCD] | n.fault[cfp_pkg::FI_SCC]);
    // Write channels are taken independently, in either order
    if (AWVALID_I && aw_rdy) begin
      n.aw_got = 1'b1;
      n.waddr = AWADDR_I;
    end
    if (WVALID_I && w_rdy) begin
      n.w_got = 1'b1;
      n.wdata = WDATA_I;
      n.wstrb = WSTRB_I;
    end
    if (s.bvalid && BREADY_I) begin
      n.bvalid = 1'b0;
    end
    // Commit once both halves are held
    if (s.aw_got && s.w_got && !s.bvalid) begin
      n.aw_got = 1'b0;
      n.w_got = 1'b0;
      n.bvalid = 1'b1;
      n.bresp = cfp_pkg::RESP_OKAY;
      case (wsel)
        cfp_pkg::SEL_DLY: begin
          n.dly = cfp_pkg::cfp_dly_s'(8'(merge(32'(s.dly), s.wdata, s.wstrb)));
        end
        cfp_pkg::SEL_THR: begin
          n.thr = clamp(cfp_pkg::cfp_thr_s'(21'(merge(32'(s.thr), s.wdata, s.wstrb))));
        end
        cfp_pkg::SEL_STAT: begin
          n.bresp = cfp_pkg::RESP_OKAY;
        end
        default: begin
          n.bresp = cfp_pkg::RESP_SLVERR;
        end
      endcase
    end
    // Read path
    if (s.rvalid && RREADY_I) begin
      n.rvalid = 1'b0;
    end
    if (ARVALID_I && ar_rdy) begin
      n.rvalid = 1'b1;
      n.rresp = cfp_pkg::RESP_OKAY;
      case (rsel)
        cfp_pkg::SEL_DLY: begin
          n.rdata = 32'(s.dly);
        end
        cfp_pkg::SEL_THR: begin
          n.rdata = 32'(s.thr);
        end
        cfp_pkg::SEL_STAT: begin
          n.rdata = 32'({s.dsg_gate, s.chg_gate, s.fault});
        end
        default: begin
          n.rdata = '0;
          n.rresp = cfp_pkg::RESP_SLVERR;
        end
      endcase
    end
  end

  // State register; reset puts both FETs on with no fault latched
  always_ff @(posedge REF_CLK_I) begin
    if (RST_I) begin
      s <= cfp_pkg::STATE_RST;
    end else begin
      s <= n;
    end
  end

  // ****************************************************************
  // Outputs
  // ****************************************************************
  assign CHARGE_GATE_DRIVE_O = s.chg_gate;
  assign DISCHARGE_GATE_DRIVE_O = s.dsg_gate;
  assign THRESH_SEL_O = s.thr;
  assign AWREADY_O = aw_rdy;
  assign WREADY_O = w_rdy;
  assign BVALID_O = s.bvalid;
  assign BRESP_O = s.bresp;
  assign ARREADY_O = ar_rdy;
  assign RVALID_O = s.rvalid;
  assign RDATA_O = s.rdata;
  assign RRESP_O = s.rresp;

  // ****************************************************************
  // Assertions
  // ****************************************************************
  default clocking cb @(posedge REF_CLK_I);
  endclocking
  default disable iff (RST_I);

  // Last tick of a running detection timer
  sequence s_exp_ovp;
    !s.fault[cfp_pkg::FI_OVP] && cond[cfp_pkg::FI_OVP] && s.ms_tick &&
      s.det[cfp_pkg::FI_OVP] == lim[cfp_pkg::FI_OVP] - 13'h1;
  endsequence
  sequence s_exp_uvp;
    !s.fault[cfp_pkg::FI_UVP] && cond[cfp_pkg::FI_UVP] && s.ms_tick &&
      s.det[cfp_pkg::FI_UVP] == lim[cfp_pkg::FI_UVP] - 13'h1;
  endsequence
  sequence s_exp_ocd;
    !s.fault[cfp_pkg::FI_OCD] && cond[cfp_pkg::FI_OCD] && s.ms_tick &&
      s.det[cfp_pkg::FI_OCD] == lim[cfp_pkg::FI_OCD] - 13'h1;
  endsequence
  sequence s_exp_occ;
    !s.fault[cfp_pkg::FI_OCC] && cond[cfp_pkg::FI_OCC] && s.ms_tick &&
      s.det[cfp_pkg::FI_OCC] == cfp_pkg::OCC_DLY_MS[s.dly.occ] - 13'h1;
  endsequence

  property p_ovp_dly;
    s_exp_ovp |=> s.fault[cfp_pkg::FI_OVP] && !CHARGE_GATE_DRIVE_O;
  endproperty
  a_ovp_dly: assert property (p_ovp_dly) else $error("overcharge delay expiry missed");

  property p_uvp_dly;
    s_exp_uvp |=> !DISCHARGE_GATE_DRIVE_O;
  endproperty
  a_uvp_dly: assert property (p_uvp_dly) else $error("over-discharge delay expiry missed");

  property p_ocd_dly;
    s_exp_ocd |=> s.fault[cfp_pkg::FI_OCD] && !DISCHARGE_GATE_DRIVE_O;
  endproperty
  a_ocd_dly: assert property (p_ocd_dly) else $error("discharge overcurrent expiry missed");

  property p_occ_dly;
    s_exp_occ |=> s.fault[cfp_pkg::FI_OCC] && !CHARGE_GATE_DRIVE_O;
  endproperty
  a_occ_dly: assert property (p_occ_dly) else $error("charge overcurrent expiry missed");

  property p_scc_dly;
    $rose(s.fault[cfp_pkg::FI_SCC]) |->
      $past(s.det[cfp_pkg::FI_SCC]) == cfp_pkg::SCC_DLY_US - 13'h1 && $past(s.us_tick);
  endproperty
  a_scc_dly: assert property (p_scc_dly) else $error("short circuit fault not at fixed delay");

  property p_thr_range;
    THRESH_SEL_O.overcharge_fault <= cfp_pkg::OVP_CODE_MAX && THRESH_SEL_O.overdischarge_fault <= cfp_pkg::UVP_CODE_MAX &&
      THRESH_SEL_O.discharge_overcurrent_fault <= cfp_pkg::OCD_CODE_MAX && THRESH_SEL_O.occ <= cfp_pkg::OCC_CODE_MAX;
  endproperty
  a_thr_range: assert property (p_thr_range) else $error("threshold code out of range");

  property p_gates;
    CHARGE_GATE_DRIVE_O == !(s.fault[cfp_pkg::FI_OVP] || s.fault[cfp_pkg::FI_OCC]) &&
      DISCHARGE_GATE_DRIVE_O == !(s.fault[cfp_pkg::FI_UVP] || s.fault[cfp_pkg::FI_OCD] || s.fault[cfp_pkg::FI_SCC]);
  endproperty
  a_gates: assert property (p_gates) else $error("gate drive disagrees with fault state");

  property p_restart;
    !s.fault[cfp_pkg::FI_OVP] && !cond[cfp_pkg::FI_OVP] |=> s.det[cfp_pkg::FI_OVP] == '0;
  endproperty
  a_restart: assert property (p_restart) else $error("detection timer kept counting");

  property p_ovp_rel;
    $fell(s.fault[cfp_pkg::FI_OVP]) |-> $past(rel[cfp_pkg::FI_OVP] && !cond[cfp_pkg::FI_OVP] && s.ms_tick) &&
      $past(s.rec[cfp_pkg::FI_OVP]) == REC_MS - 13'h1;
  endproperty
  a_ovp_rel: assert property (p_ovp_rel) else $error("overcharge released early");

  property p_uvp_rel;
    $fell(s.fault[cfp_pkg::FI_UVP]) |-> $past(cmp.uvp_above_hys && cmp.diff_gt_1v);
  endproperty
  a_uvp_rel: assert property (p_uvp_rel) else $error("over-discharge released without recovery");

  property p_dsg_rel;
    $fell(s.fault[cfp_pkg::FI_OCD]) || $fell(s.fault[cfp_pkg::FI_SCC]) |-> $past(cmp.diff_gt_1v);
  endproperty
  a_dsg_rel: assert property (p_dsg_rel) else $error("discharge fault cleared with load present");

  property p_occ_rel;
    $fell(s.fault[cfp_pkg::FI_OCC]) |-> $past(cmp.occ_release && !cmp.occ_below);
  endproperty
  a_occ_rel: assert property (p_occ_rel) else $error("charge overcurrent cleared early");

endmodule

//--- verification/cfp_fet_model.sv
// Behavioural model of the external charge and discharge power FETs
`timescale 1ns/1ps
module cfp_fet_model (
  // Gate drives from the protector
  input wire logic chg_gate_i,
  input wire logic dsg_gate_i,
  // Conduction state of each FET
  output logic chg_on_o,
  output logic dsg_on_o
);
  // ****************************************************************
  // FET conduction
  // ****************************************************************
  // Floating or unknown gate leaves the FET off, so a bad drive never reads as on
  assign chg_on_o = (chg_gate_i === 1'b1);
  assign dsg_on_o = (dsg_gate_i === 1'b1);
endmodule

//--- verification/testbench.sv
// Self-checking bench for the cell fault protection timer logic
`timescale 1ns/1ps
`define CHK(g, e) begin checks_done++; if ((g) !== (e)) begin mismatches++; $display("BAD t=%0t got=%0h exp=%0h", $time, g, e); end end
module testbench;
  // ****************************************************************
  // Clock, reset and stimulus
  // ****************************************************************
  localparam int PER = 4;
  localparam logic [8:0] IDLE = 9'h11A;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic [8:0] cmp = IDLE;
  logic [3:0] awaddr = 4'h0;
  logic [3:0] araddr = 4'h0;
  logic [31:0] wdata = 32'h0;
  logic [3:0] wstrb = 4'hF;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic chg_gate, dsg_gate, chg_on, dsg_on, awready, wready, bvalid, arready, rvalid;
  logic [1:0] bresp, rresp;
  logic [31:0] rdata;
  cfp_pkg::cfp_thr_s thr;
  int mismatches = 0;
  int checks_done = 0;

  // Half period of the 200 MHz clock
  always #2.5 clk = ~clk;

  // Ticks shortened so one ms tick is four cycles
  cfp_top #(.US_DIV(16'h2), .MS_DIV(16'h2), .REC_MS(13'h2)) DUT (
    .REF_CLK_I(clk), .RST_I(rst), .COMPARATOR_I(cfp_pkg::cfp_cmp_s'(cmp)),
    .CHARGE_GATE_DRIVE_O(chg_gate), .DISCHARGE_GATE_DRIVE_O(dsg_gate), .THRESH_SEL_O(thr),
    .AWADDR_I(awaddr), .AWVALID_I(awvalid), .AWREADY_O(awready), .WDATA_I(wdata), .WSTRB_I(wstrb),
    .WVALID_I(wvalid), .WREADY_O(wready), .BRESP_O(bresp), .BVALID_O(bvalid), .BREADY_I(bready),
    .ARADDR_I(araddr), .ARVALID_I(arvalid), .ARREADY_O(arready), .RDATA_O(rdata), .RRESP_O(rresp),
    .RVALID_O(rvalid), .RREADY_I(rready));

  cfp_fet_model u_fet (.chg_gate_i(chg_gate), .dsg_gate_i(dsg_gate), .chg_on_o(chg_on), .dsg_on_o(dsg_on));

  // ****************************************************************
  // Register bus tasks
  // ****************************************************************
  // Each channel is released at the edge that takes it; a lost answer ends on a bound
  // Handshakes are judged mid-cycle, where the readies have settled, and acted on at the next edge
  task automatic wr(input logic [3:0] a, input logic [31:0] d, output logic [1:0] r);
    int n;
    bit aw_hs;
    bit w_hs;
    bit b_hs;
    n = 0;
    r = 2'h1;
    @(posedge clk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    while (n < 50) begin
      @(negedge clk);
      aw_hs = awvalid && awready;
      w_hs = wvalid && wready;
      b_hs = bvalid;
      if (b_hs) r = bresp;
      @(posedge clk);
      n++;
      if (aw_hs) awvalid <= 1'b0;
      if (w_hs) wvalid <= 1'b0;
      if (b_hs) begin
        bready <= 1'b0;
        n = 99;
      end
    end
    `CHK(n, 99)
  endtask

  task automatic rd(input logic [3:0] a, output logic [31:0] d, output logic [1:0] r);
    int n;
    bit ar_hs;
    bit r_hs;
    n = 0;
    d = 32'h0;
    r = 2'h1;
    @(posedge clk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    while (n < 50) begin
      @(negedge clk);
      ar_hs = arvalid && arready;
      r_hs = rvalid;
      if (r_hs) begin
        d = rdata;
        r = rresp;
      end
      @(posedge clk);
      n++;
      if (ar_hs) arvalid <= 1'b0;
      if (r_hs) begin
        rready <= 1'b0;
        n = 99;
      end
    end
    `CHK(n, 99)
  endtask

  // ****************************************************************
  // Fault scenario
  // ****************************************************************
  function automatic logic gate_of(input bit chg);
    return chg ? chg_on : dsg_on;
  endfunction

  // Condition c until the gate drops, then h which must not release, then recovery
  task automatic flt(input logic [8:0] c, input logic [8:0] h, input bit chg, input int lim, input int st);
    int n;
    logic [31:0] d;
    logic [1:0] r;
    n = 0;
    @(posedge clk);
    cmp <= c;
    // Gate is looked at mid-cycle so the edge that moves it never races the look
    while (gate_of(chg) === 1'b1 && n < lim + 40) begin
      @(negedge clk);
      n++;
    end
    `CHK(n >= lim - 1 && n <= lim + 5, 1'b1)
    rd(4'h8, d, r);
    `CHK(d[6:0], {chg, !chg, 5'(1 << st)})
    cmp <= h;
    repeat (20) @(posedge clk);
    `CHK(gate_of(chg), 1'b0)
    cmp <= IDLE;
    repeat (3) @(posedge clk);
    `CHK(gate_of(chg), 1'b0)
    n = 0;
    while (gate_of(chg) !== 1'b1 && n < 40) begin
      @(negedge clk);
      n++;
    end
    `CHK(n < 20, 1'b1)
    @(posedge clk);
  endtask

  // ****************************************************************
  // Main sequence
  // ****************************************************************
  initial begin
    logic [31:0] d;
    logic [1:0] r;
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    `CHK({chg_gate, dsg_gate}, 2'b11)
    rd(4'h0, d, r);
    `CHK(d, 32'h0)
    rd(4'h4, d, r);
    `CHK(d, 32'h0)
    wr(4'hC, 32'h1, r);
    `CHK(r, cfp_pkg::RESP_SLVERR)
    rd(4'hC, d, r);
    `CHK({r, d}, {cfp_pkg::RESP_SLVERR, 32'h0})
    // Out of range codes are clamped to the top legal value of each field
    wr(4'h4, 32'hFFFFFFFF, r);
    `CHK(thr, {2'h3, 5'h16, 5'h16, 5'h10, 4'hF})
    // Only the low byte lane is written: ovp clears, the upper lanes keep their codes
    wstrb <= 4'h1;
    wr(4'h4, 32'h0, r);
    wstrb <= 4'hF;
    `CHK(thr, {2'h3, 5'h16, 5'h16, 5'h10, 4'h0})
    // Status is read only: a write is taken and ignored
    wr(4'h8, 32'hFF, r);
    `CHK(r, cfp_pkg::RESP_OKAY)
    rd(4'h8, d, r);
    `CHK(d, 32'h60)
    for (int s = 0; s < 4; s++) begin
      wr(4'h0, {24'h0, {4{2'(s)}}}, r);
      `CHK(r, cfp_pkg::RESP_OKAY)
      rd(4'h0, d, r);
      `CHK(d, {24'h0, {4{2'(s)}}})
      flt(9'h119, 9'h118, 1'b1, cfp_pkg::OVP_DLY_MS[s] * PER, 0);
      flt(9'h116, 9'h10A, 1'b0, cfp_pkg::UVP_DLY_MS[s] * PER, 1);
      flt(9'h12A, 9'h10A, 1'b0, cfp_pkg::OCD_DLY_MS[s] * PER, 2);
      flt(9'h14A, 9'h10A, 1'b0, 500, 3);
      flt(9'h09A, 9'h01A, 1'b1, cfp_pkg::OCC_DLY_MS[s] * PER, 4);
    end
    // A short burst must not leave a partial count behind
    cmp <= 9'h09A;
    repeat (40) @(posedge clk);
    cmp <= IDLE;
    repeat (4) @(posedge clk);
    flt(9'h09A, 9'h01A, 1'b1, cfp_pkg::OCC_DLY_MS[3] * PER, 4);
    tally_and_finish;
  end

  // Watchdog well beyond the expected run of about thirty-three thousand cycles
  initial begin
    #300000;
    mismatches++;
    tally_and_finish;
  end

  task automatic tally_and_finish;
    $display("checks=%0d mismatches=%0d", checks_done, mismatches);
    if (mismatches == 0 && checks_done > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask
endmodule
